//--- flash_map_pkg.sv
// flash map package: global address windows, configuration field layout,
// register offsets, field positions and reset values of the flash module.
// assumes a byte-wide register port and 18-bit global addresses.
// Contract
// - program flash block decodes at 0x2_0000 through 0x3_FFFF, holding config field
// - lower protectable region starts at 0x3_8000 and grows upward
// - higher protectable region grows downward from 0x3_FFFF, covering vectors
// - remaining program flash addresses form a third protectable region
// - eight-byte backdoor key sits at 0x3_FF00 through 0x3_FF07
// - protection defaults come from bytes 0x3_FF0C and 0x3_FF0D
// - option byte comes from 0x3_FF0E, security byte from 0x3_FF0F
// - two-byte version identifier at 0x0_40B6 to 0x0_40B7
// - 64-byte one-time field at 0x0_40C0 through 0x0_40FF
// - 4096-byte data flash at 0x0_4400 through 0x0_53FF
// - 768-byte scratch ram at 0x0_5800 through 0x0_5AFF only when enabled
// - twenty byte-wide registers at offsets 0x0000 through 0x0013; only nine are implemented here, the rest read zero
// - unimplemented space reads undefined, writes there are ignored
package flash_map_pkg;
	localparam int ADDR_W = 18;
	localparam int REG_AW = 5;
	localparam logic [17:0] PFLASH_LO = 18'h20000;
	localparam logic [17:0] PFLASH_HI = 18'h3ffff;
	localparam logic [17:0] LOW_REGION_BASE = 18'h38000;
	localparam logic [17:0] KEY_LO = 18'h3ff00;
	localparam logic [17:0] KEY_HI = 18'h3ff07;
	localparam logic [17:0] RSVD_CFG_LO = 18'h3ff08;
	localparam logic [17:0] PPROT_BYTE = 18'h3ff0c;
	localparam logic [17:0] DPROT_BYTE = 18'h3ff0d;
	localparam logic [17:0] OPTION_BYTE = 18'h3ff0e;
	localparam logic [17:0] SECURITY_BYTE = 18'h3ff0f;
	localparam logic [17:0] VERSION_LO = 18'h040b6;
	localparam logic [17:0] VERSION_HI = 18'h040b7;
	localparam logic [17:0] OTP_LO = 18'h040c0;
	localparam logic [17:0] OTP_HI = 18'h040ff;
	localparam logic [17:0] DFLASH_LO = 18'h04400;
	localparam logic [17:0] DFLASH_HI = 18'h053ff;
	localparam logic [17:0] SCRATCH_LO = 18'h05800;
	localparam logic [17:0] SCRATCH_HI = 18'h05aff;
	// higher region sizes 2k,4k,8k,16k; lower region 2k,4k,8k,16k
	localparam logic [17:0] REGION_UNIT = 18'h00800;
	// register offsets
	localparam logic [4:0] OFS_CLKDIV = 5'h00;
	localparam logic [4:0] OFS_SEC = 5'h01;
	localparam logic [4:0] OFS_COMMAND_WORD_INDEX = 5'h02;
	localparam logic [4:0] OFS_CNFG = 5'h04;
	localparam logic [4:0] OFS_ERCNFG = 5'h05;
	localparam logic [4:0] OFS_STAT = 5'h06;
	localparam logic [4:0] OFS_ERSTAT = 5'h07;
	localparam logic [4:0] OFS_PPROT = 5'h08;
	localparam logic [4:0] OFS_DPROT = 5'h09;
	localparam logic [4:0] OFS_LAST = 5'h13;
	// writable / readable bit masks
	localparam logic [7:0] CLKDIV_DIV_MASK = 8'h3f;
	localparam int DIVLD_BIT = 7;
	localparam int DIVLCK_BIT = 6;
	localparam logic [7:0] COMMAND_WORD_INDEX_MASK = 8'h07;
	localparam logic [7:0] CNFG_MASK = 8'h93;
	localparam logic [7:0] ERCNFG_MASK = 8'h03;
	localparam logic [7:0] ERSTAT_MASK = 8'h03;
	localparam logic [7:0] DPROT_MASK = 8'h8f;
	localparam int COMMAND_COMPLETE_FLAG_BIT = 7;
	localparam int ACCESS_ERROR_BIT = 5;
	localparam int PROTECTION_VIOLATION_BIT = 4;
	localparam logic [7:0] ZERO8 = 8'h00;
	localparam logic [7:0] ERASED8 = 8'hff;
	localparam logic [7:0] UNDEF_READ = 8'h00;
	// field positions in the program flash protection byte
	localparam int PP_OPEN = 7;
	localparam int PP_HDIS = 5;
	localparam int PP_LDIS = 2;
	typedef enum logic [2:0] {
		REGION_NONE_type_e, REGION_PFLASH, REGION_CONFIG, REGION_INFO,
		REGION_DFLASH, REGION_SCRATCH
	} region_type;
endpackage

//--- flash_decode_if.sv
`timescale 1ns/1ps
// address probe carried from the register block to the map decoder.
// assumes both ends run on the same clock; the decode is combinational.
interface flash_decode_if;
	logic [17:0] addr;
	logic scratch_ram_enable;
	logic [7:0] pprot;
	flash_map_pkg::region_type region;
	logic protected_hit;
	logic key_hit;
	modport requester (output addr, output scratch_ram_enable,
		output pprot, input region, input protected_hit, input key_hit);
	modport decoder (input addr, input scratch_ram_enable, input pprot,
		output region, output protected_hit, output key_hit);
endinterface

//--- flash_map_decode.sv
`timescale 1ns/1ps
// global address decoder for the flash module windows and protection.
// assumes the protection byte is stable while an address is probed.
module flash_map_decode (
	flash_decode_if.decoder dec
);
	function automatic logic in_range(input logic [17:0] a,
		input logic [17:0] lo, input logic [17:0] hi);
		in_range = (a >= lo) && (a <= hi);
	endfunction

	// size code n spans one 2 KiB unit doubled n times
	function automatic logic [17:0] region_span(input logic [1:0] code);
		region_span = flash_map_pkg::REGION_UNIT << code;
	endfunction

	logic [17:0] high_base;
	logic [17:0] low_top;
	logic in_low;
	logic in_high;
	logic in_pf;

	always_comb begin
		high_base = flash_map_pkg::PFLASH_HI
			- region_span(dec.pprot[4:3]) + 18'h00001;
		low_top = flash_map_pkg::LOW_REGION_BASE
			+ region_span(dec.pprot[1:0]) - 18'h00001;
		in_pf = in_range(dec.addr, flash_map_pkg::PFLASH_LO,
			flash_map_pkg::PFLASH_HI);
		in_high = in_pf && (dec.addr >= high_base);
		in_low = in_range(dec.addr, flash_map_pkg::LOW_REGION_BASE, low_top);
	end

	always_comb begin
		dec.region = flash_map_pkg::REGION_NONE_type_e;
		if (in_range(dec.addr, flash_map_pkg::KEY_LO,
			flash_map_pkg::SECURITY_BYTE))
			dec.region = flash_map_pkg::REGION_CONFIG;
		else if (in_pf)
			dec.region = flash_map_pkg::REGION_PFLASH;
		else if (in_range(dec.addr, flash_map_pkg::VERSION_LO,
			flash_map_pkg::VERSION_HI) || in_range(dec.addr,
			flash_map_pkg::OTP_LO, flash_map_pkg::OTP_HI))
			dec.region = flash_map_pkg::REGION_INFO;
		else if (in_range(dec.addr, flash_map_pkg::DFLASH_LO,
			flash_map_pkg::DFLASH_HI))
			dec.region = flash_map_pkg::REGION_DFLASH;
		else if (dec.scratch_ram_enable && in_range(dec.addr,
			flash_map_pkg::SCRATCH_LO, flash_map_pkg::SCRATCH_HI))
			dec.region = flash_map_pkg::REGION_SCRATCH;
	end

	always_comb begin
		dec.key_hit = in_range(dec.addr, flash_map_pkg::KEY_LO,
			flash_map_pkg::KEY_HI);
		// open bit set means unprotected outside the enabled regions
		dec.protected_hit = in_pf && (
			(in_high && !dec.pprot[flash_map_pkg::PP_HDIS]) ||
			(in_low && !dec.pprot[flash_map_pkg::PP_LDIS]) ||
			(!in_high && !in_low && !dec.pprot[flash_map_pkg::PP_OPEN]));
	end
endmodule

//--- flash_regs.sv
`timescale 1ns/1ps
// flash module register block and global address map front end.
// assumes the config field bytes arrive on cfg_* inputs, loaded on the cfg_load strobe.
module flash_regs (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [4:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [7:0] reg_rdata,
	input wire logic cfg_load,
	input wire logic [7:0] cfg_pprot,
	input wire logic [7:0] cfg_dprot,
	input wire logic [7:0] cfg_option,
	input wire logic [7:0] cfg_security,
	input wire logic command_complete_flag,
	input wire logic scratch_ram_enable,
	input wire logic [17:0] probe_addr,
	output flash_map_pkg::region_type probe_region,
	output logic probe_protected,
	output logic probe_key,
	output logic [7:0] option_byte
);
	flash_decode_if dec_bus ();
	logic [7:0] clkdiv;
	logic [7:0] security;
	logic [7:0] command_word_index;
	logic [7:0] cnfg;
	logic [7:0] ercnfg;
	logic [7:0] erstat;
	logic [7:0] pprot;
	logic [7:0] dprot;
	logic [7:0] next_rdata;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		hit = (a == o);
	endfunction

	assign dec_bus.addr = probe_addr;
	assign dec_bus.scratch_ram_enable = scratch_ram_enable;
	assign dec_bus.pprot = pprot;
	flash_map_decode u_decode (.dec(dec_bus.decoder));

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			probe_region <= flash_map_pkg::REGION_NONE_type_e;
			probe_protected <= 1'b0;
			probe_key <= 1'b0;
		end else begin
			probe_region <= dec_bus.region;
			probe_protected <= dec_bus.protected_hit;
			probe_key <= dec_bus.key_hit;
		end
	end

	// loaded copies of configuration bytes
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			security <= flash_map_pkg::ERASED8;
			option_byte <= flash_map_pkg::ERASED8;
		end else if (cfg_load) begin
			security <= cfg_security;
			option_byte <= cfg_option;
		end
	end

	// divider: bit 7 records a write, bit 6 locks the divider field
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			clkdiv <= flash_map_pkg::ZERO8;
		else if (reg_write && hit(reg_addr, flash_map_pkg::OFS_CLKDIV)) begin
			clkdiv[flash_map_pkg::DIVLD_BIT] <= 1'b1;
			if (reg_wdata[flash_map_pkg::DIVLCK_BIT])
				clkdiv[flash_map_pkg::DIVLCK_BIT] <= 1'b1;
			if (!clkdiv[flash_map_pkg::DIVLCK_BIT])
				clkdiv[5:0] <= reg_wdata[5:0];
		end
	end

	// command-active writes are the software's hazard; no guard here
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			command_word_index <= flash_map_pkg::ZERO8;
			cnfg <= flash_map_pkg::ZERO8;
			ercnfg <= flash_map_pkg::ZERO8;
			erstat <= flash_map_pkg::ZERO8;
		end else if (reg_write) begin
			if (hit(reg_addr, flash_map_pkg::OFS_COMMAND_WORD_INDEX))
				command_word_index <= reg_wdata & flash_map_pkg::COMMAND_WORD_INDEX_MASK;
			if (hit(reg_addr, flash_map_pkg::OFS_CNFG))
				cnfg <= reg_wdata & flash_map_pkg::CNFG_MASK;
			if (hit(reg_addr, flash_map_pkg::OFS_ERCNFG))
				ercnfg <= reg_wdata & flash_map_pkg::ERCNFG_MASK;
			if (hit(reg_addr, flash_map_pkg::OFS_ERSTAT))
				erstat <= erstat & ~(reg_wdata & flash_map_pkg::ERSTAT_MASK);
		end
	end

	// protection loads on cfg_load; software writes may set or clear any pprot bit afterwards, but only dprot bits 7 and 3:0
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pprot <= flash_map_pkg::ERASED8;
			dprot <= flash_map_pkg::ERASED8 & flash_map_pkg::DPROT_MASK;
		end else if (cfg_load) begin
			pprot <= cfg_pprot;
			dprot <= cfg_dprot & flash_map_pkg::DPROT_MASK;
		end else if (reg_write) begin
			if (hit(reg_addr, flash_map_pkg::OFS_PPROT))
				pprot <= reg_wdata;
			if (hit(reg_addr, flash_map_pkg::OFS_DPROT))
				dprot <= reg_wdata & flash_map_pkg::DPROT_MASK;
		end
	end

	always_comb begin
		next_rdata = flash_map_pkg::ZERO8;
		case (reg_addr)
			flash_map_pkg::OFS_CLKDIV: next_rdata = clkdiv;
			flash_map_pkg::OFS_SEC: next_rdata = security;
			flash_map_pkg::OFS_COMMAND_WORD_INDEX: next_rdata = command_word_index;
			flash_map_pkg::OFS_CNFG: next_rdata = cnfg;
			flash_map_pkg::OFS_ERCNFG: next_rdata = ercnfg;
			flash_map_pkg::OFS_STAT: begin
				next_rdata[flash_map_pkg::COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag;
			end
			flash_map_pkg::OFS_ERSTAT: next_rdata = erstat;
			flash_map_pkg::OFS_PPROT: next_rdata = pprot;
			flash_map_pkg::OFS_DPROT: next_rdata = dprot;
			default: begin
				// reserved slots and beyond read as a fixed pattern
				if (reg_addr > flash_map_pkg::OFS_LAST)
					next_rdata = flash_map_pkg::UNDEF_READ;
				else
					next_rdata = flash_map_pkg::ZERO8;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			reg_rdata <= flash_map_pkg::ZERO8;
		else if (reg_read)
			reg_rdata <= next_rdata;
		else
			reg_rdata <= flash_map_pkg::ZERO8;
	end

	a_divider_lock: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		clkdiv[flash_map_pkg::DIVLCK_BIT] |=> $stable(clkdiv[5:0]))
		else $error("divider field changed while locked");
	a_read_timing: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		reg_read && hit(reg_addr, flash_map_pkg::OFS_PPROT) |=>
		reg_rdata == $past(pprot))
		else $error("protection read data wrong");
	a_command_word_index_bits: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		(command_word_index & ~flash_map_pkg::COMMAND_WORD_INDEX_MASK) == flash_map_pkg::ZERO8)
		else $error("unimplemented index bits set");
	a_cfg_load: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		cfg_load |=> security == $past(cfg_security)
		&& option_byte == $past(cfg_option))
		else $error("config bytes not loaded");
	a_pprot_load: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		cfg_load |=> pprot == $past(cfg_pprot))
		else $error("protection byte not loaded");
	a_scratch_gate: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		!scratch_ram_enable |=> probe_region != flash_map_pkg::REGION_SCRATCH)
		else $error("scratch ram mapped while disabled");
	a_key_window: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		probe_addr == flash_map_pkg::KEY_LO |=> probe_key)
		else $error("key byte not decoded");
	a_dflash_map: assert property (
		@(posedge sys_clk) disable iff (!rst_b)
		probe_addr == flash_map_pkg::DFLASH_HI |=>
		probe_region == flash_map_pkg::REGION_DFLASH)
		else $error("data flash top not decoded");
endmodule

//--- test_flash_map_register_decode.sv
// self-checking bench for the flash register block and its map decoder.
// assumes flash_map_pkg is compiled first; no separate partner model.
`timescale 1ns/1ps
module test_flash_map_register_decode;
	logic sys_clk = 1'b0;
	logic rst_b = 1'b0;
	logic [4:0] reg_addr = 5'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [7:0] reg_rdata;
	logic cfg_load = 1'b0;
	logic [7:0] cfg_pprot = 8'hff;
	logic [7:0] cfg_dprot = 8'hff;
	logic [7:0] cfg_option = 8'hff;
	logic [7:0] cfg_security = 8'hff;
	logic command_complete_flag = 1'b1;
	logic scratch_ram_enable = 1'b0;
	logic [17:0] probe_addr = 18'h00000;
	flash_map_pkg::region_type probe_region;
	logic probe_protected;
	logic probe_key;
	logic [7:0] option_byte;
	int num_errors = 0;
	int cmp_count = 0;
	flash_regs DUT (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .cfg_load(cfg_load), .cfg_pprot(cfg_pprot),
		.cfg_dprot(cfg_dprot), .cfg_option(cfg_option),
		.cfg_security(cfg_security),
		.command_complete_flag(command_complete_flag),
		.scratch_ram_enable(scratch_ram_enable), .probe_addr(probe_addr),
		.probe_region(probe_region), .probe_protected(probe_protected),
		.probe_key(probe_key), .option_byte(option_byte));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [17:0] got, input logic [17:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// writes only while no command is active keep the register file sane
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		reg_write <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		reg_read <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_read <= 1'b0;
		#1;
		check({10'h0, reg_rdata}, {10'h0, exp});
	endtask
	task automatic pr(input logic [17:0] a, input flash_map_pkg::region_type r,
		input logic p, input logic k);
		@(posedge sys_clk);
		probe_addr <= a;
		@(posedge sys_clk);
		#1;
		check({15'h0, probe_region}, {15'h0, r});
		check({16'h0, probe_protected, probe_key}, {16'h0, p, k});
	endtask
	task automatic test_config_load;
		rd(5'h08, 8'hff);
		rd(5'h09, 8'h8f);
		rd(5'h01, 8'hff);
		check({10'h0, option_byte}, 18'h000ff);
		@(posedge sys_clk);
		cfg_pprot <= 8'ha6;
		cfg_dprot <= 8'h85;
		cfg_option <= 8'h5a;
		cfg_security <= 8'h7e;
		// the protection, option and security bytes all load in one strobe
		cfg_load <= 1'b1;
		@(posedge sys_clk);
		cfg_load <= 1'b0;
		rd(5'h08, 8'ha6);
		rd(5'h09, 8'h85);
		rd(5'h01, 8'h7e);
		check({10'h0, option_byte}, 18'h0005a);
		wr(5'h01, 8'h00);
		rd(5'h01, 8'h7e);
		$display("test_config_load done");
	endtask
	task automatic test_registers;
		wr(5'h00, 8'h45);
		rd(5'h00, 8'hc5);
		wr(5'h00, 8'h12);
		rd(5'h00, 8'hc5);
		wr(5'h02, 8'hff);
		rd(5'h02, 8'h07);
		wr(5'h04, 8'hff);
		rd(5'h04, 8'h93);
		wr(5'h05, 8'hff);
		rd(5'h05, 8'h03);
		wr(5'h09, 8'hff);
		rd(5'h09, 8'h8f);
		wr(5'h07, 8'hff);
		rd(5'h07, 8'h00);
		wr(5'h03, 8'h5a);
		rd(5'h03, 8'h00);
		wr(5'h0c, 8'h5a);
		rd(5'h0c, 8'h00);
		wr(5'h13, 8'h5a);
		rd(5'h13, 8'h00);
		rd(5'h1f, 8'h00);
		rd(5'h06, 8'h80);
		command_complete_flag <= 1'b0;
		rd(5'h06, 8'h00);
		command_complete_flag <= 1'b1;
		$display("test_registers done");
	endtask
	task automatic test_decode;
		wr(5'h08, 8'hff);
		pr(18'h1ffff, flash_map_pkg::REGION_NONE_type_e, 1'b0, 1'b0);
		pr(18'h20000, flash_map_pkg::REGION_PFLASH, 1'b0, 1'b0);
		pr(18'h3ffff, flash_map_pkg::REGION_PFLASH, 1'b0, 1'b0);
		pr(18'h3ff00, flash_map_pkg::REGION_CONFIG, 1'b0, 1'b1);
		pr(18'h3ff07, flash_map_pkg::REGION_CONFIG, 1'b0, 1'b1);
		pr(18'h3ff08, flash_map_pkg::REGION_CONFIG, 1'b0, 1'b0);
		pr(18'h3ff0f, flash_map_pkg::REGION_CONFIG, 1'b0, 1'b0);
		pr(18'h040b6, flash_map_pkg::REGION_INFO, 1'b0, 1'b0);
		pr(18'h040b7, flash_map_pkg::REGION_INFO, 1'b0, 1'b0);
		pr(18'h040c0, flash_map_pkg::REGION_INFO, 1'b0, 1'b0);
		pr(18'h040ff, flash_map_pkg::REGION_INFO, 1'b0, 1'b0);
		pr(18'h04400, flash_map_pkg::REGION_DFLASH, 1'b0, 1'b0);
		pr(18'h053ff, flash_map_pkg::REGION_DFLASH, 1'b0, 1'b0);
		pr(18'h05400, flash_map_pkg::REGION_NONE_type_e, 1'b0, 1'b0);
		pr(18'h05800, flash_map_pkg::REGION_NONE_type_e, 1'b0, 1'b0);
		scratch_ram_enable <= 1'b1;
		pr(18'h05800, flash_map_pkg::REGION_SCRATCH, 1'b0, 1'b0);
		pr(18'h05aff, flash_map_pkg::REGION_SCRATCH, 1'b0, 1'b0);
		pr(18'h05b00, flash_map_pkg::REGION_NONE_type_e, 1'b0, 1'b0);
		// lower region enabled with the smallest size: one 2 KiB unit
		wr(5'h08, 8'ha0);
		pr(18'h38000, flash_map_pkg::REGION_PFLASH, 1'b1, 1'b0);
		pr(18'h387ff, flash_map_pkg::REGION_PFLASH, 1'b1, 1'b0);
		pr(18'h38800, flash_map_pkg::REGION_PFLASH, 1'b0, 1'b0);
		wr(5'h08, 8'h84);
		pr(18'h3f800, flash_map_pkg::REGION_PFLASH, 1'b1, 1'b0);
		pr(18'h3f7ff, flash_map_pkg::REGION_PFLASH, 1'b0, 1'b0);
		// open bit clear: every program flash address outside the two regions is protected
		wr(5'h08, 8'h24);
		pr(18'h20000, flash_map_pkg::REGION_PFLASH, 1'b1, 1'b0);
		pr(18'h1ffff, flash_map_pkg::REGION_NONE_type_e, 1'b0, 1'b0);
		$display("test_decode done");
	endtask
	task automatic stop_test;
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	initial begin
		#20000;
		num_errors++;
		$display("Error at %0t: watchdog expired", $time);
		stop_test();
	end
	initial begin
		repeat (4) @(posedge sys_clk);
		rst_b <= 1'b1;
		test_config_load();
		test_registers();
		test_decode();
		stop_test();
	end
endmodule
